// File: verilog/srims_pkg.sv
// Shared constants and types for the remote input mode select block.
package srims_pkg;
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned HOLD_MS        = 50;
	localparam int unsigned HOLD_CYC       = (CLK_HZ / 1000) * HOLD_MS;
	localparam int unsigned HOLD_W         = 20;
	localparam logic        RST_PROP_ONLY  = 1'h0;
	localparam logic        RST_TL_SEL     = 1'h0;
	localparam logic        RST_GAIN_SEL   = 1'h0;
	localparam logic        RST_CMD_SRC    = 1'h0;
	localparam logic        RST_INCR_SEL   = 1'h0;
	localparam logic        RST_CLEAR_IN   = 1'h0;
	localparam logic [1:0]  CMD_SRC_TABLE  = 2'h0;
	localparam logic [1:0]  CMD_SRC_REG    = 2'h1;
	localparam logic [1:0]  POS_ABSOLUTE   = 2'h0;
	localparam logic [1:0]  POS_INCREMENT  = 2'h1;
	typedef enum logic [1:0] {
		SRIMS_RUN,
		SRIMS_STOP
	} srims_stop_t;
endpackage : srims_pkg

// File: verilog/srims_link_if.sv
// Remote input bit link between the network master and the servo driver.
interface srims_link_if;
	logic proportional_only_select;
	logic internal_torque_limit_select;
	logic alternate_gain_select;
	logic command_source_select;
	logic incremental_select;
	logic alarm_clear_input;
	logic movement_complete_flag;
	modport device (
		input  proportional_only_select,
		input  internal_torque_limit_select,
		input  alternate_gain_select,
		input  command_source_select,
		input  incremental_select,
		input  alarm_clear_input,
		output movement_complete_flag
	);
	modport master (
		output proportional_only_select,
		output internal_torque_limit_select,
		output alternate_gain_select,
		output command_source_select,
		output incremental_select,
		output alarm_clear_input,
		input  movement_complete_flag
	);
endinterface : srims_link_if

// File: verilog/srims_master.sv
// Network master end: registers remote input bits from a plain software port.
module srims_master (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic [1:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	srims_link_if.master     link
);
	import srims_pkg::*;

	localparam logic [1:0] ADDR_CTRL   = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam int unsigned B_PROP = 0;
	localparam int unsigned B_TL   = 1;
	localparam int unsigned B_GAIN = 2;
	localparam int unsigned B_SRC  = 3;
	localparam int unsigned B_INC  = 4;
	localparam int unsigned B_CLR  = 5;
	localparam int unsigned B_AUTO = 6;

	logic [6:0] ctrl_q, ctrl_d;
	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		ctrl_d  = ctrl_q;
		rdata_d = 8'h00;
		if (i_wr && i_addr == ADDR_CTRL) begin
			ctrl_d = i_wdata[6:0];
			// Gain switching is refused while auto tuning is flagged on.
			if (i_wdata[B_AUTO])
				ctrl_d[B_GAIN] = 1'h0;
		end
		if (i_rd) begin
			case (i_addr)
				ADDR_CTRL:   rdata_d = {1'h0, ctrl_q};
				// The flag comes from a flop on this same clock, so it is read directly.
				ADDR_STATUS: rdata_d = {7'h00, link.movement_complete_flag};
				default:     rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_q    <= 7'h00;
			rdata_q   <= 8'h00;
		end else begin
			ctrl_q    <= ctrl_d;
			rdata_q   <= rdata_d;
		end
	end

	assign o_rdata                           = rdata_q;
	assign link.proportional_only_select     = ctrl_q[B_PROP];
	assign link.internal_torque_limit_select = ctrl_q[B_TL];
	assign link.alternate_gain_select        = ctrl_q[B_GAIN];
	assign link.command_source_select        = ctrl_q[B_SRC];
	assign link.incremental_select           = ctrl_q[B_INC];
	// Software must never use clear as a stop while the motor runs.
	assign link.alarm_clear_input            = ctrl_q[B_CLR];
endmodule : srims_master

// File: verilog/srims_device.sv
// Servo driver end: decodes remote input bits into control mode selections.
// Summary of operation
// - Proportional select makes speed loop proportional only.
// - Torque select picks internal over forward/reverse limits.
// - Master adds proportional control at movement complete.
// - Master adds torque select for long lock.
// - Gain select switches to alternate gain set.
// - Master disables auto tuning before gain switching; here gain select is held off while auto tuning is on.
// - Source low: command from point table.
// - Source high: command from remote write registers.
// - Abs/inc honoured only with registers and absolute system.
// - Honoured input: low absolute, high incremental.
// - Clear held 50 ms clears the alarm.
// - Some alarms survive the clear input.
// - Clear without alarm cuts base only if option set.
// - Master never uses clear as stop while running.
// - Forced stop comes only from local connector.
// - Forced stop inactive: base off, brake on.
// - Forced stop active again leaves stop state.
module srims_device #(
	parameter int unsigned HOLD_CYCLES = srims_pkg::HOLD_CYC
) (
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	srims_link_if.device    link,
	input  wire logic       i_forced_stop_input,
	input  wire logic       i_alarm_raise,
	input  wire logic       i_alarm_sticky,
	input  wire logic       i_command_system_param,
	input  wire logic       i_function_select_d1_param,
	input  wire logic       i_auto_tune_on,
	input  wire logic       i_movement_done,
	output logic            o_proportional_only,
	output logic            o_internal_torque_limit,
	output logic            o_alternate_gain,
	output logic [1:0]      o_command_source,
	output logic [1:0]      o_position_mode,
	output logic            o_alarm_active,
	output logic            o_base_enable,
	output logic            o_dynamic_brake,
	output logic            o_forced_stop_state
);
	import srims_pkg::*;

	// Every output below has its own flop, the stop flag included.
	logic              emg_s1_q, emg_s1_d;
	logic              emg_s2_q, emg_s2_d;
	logic              prop_q, prop_d;
	logic              tl_q, tl_d;
	logic              gain_q, gain_d;
	logic [1:0]        src_q, src_d;
	logic [1:0]        pmode_q, pmode_d;
	logic              movement_complete_flag_q, movement_complete_flag_d;
	logic [HOLD_W-1:0] hold_q, hold_d;
	logic              fired_q, fired_d;
	logic              alarm_q, alarm_d;
	logic              sticky_q, sticky_d;
	srims_stop_t       stop_q, stop_d;
	logic              stop_flag_q, stop_flag_d;
	logic              base_q, base_d;
	logic              brake_q, brake_d;

	// The forced stop pin is the only input from outside this clock, so only it is synchronised.
	always_comb begin
		emg_s1_d = i_forced_stop_input;
		emg_s2_d = emg_s1_q;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			emg_s1_q <= 1'h0;
			emg_s2_q <= 1'h0;
		end else begin
			emg_s1_q <= emg_s1_d;
			emg_s2_q <= emg_s2_d;
		end
	end

	// The link bits come from the master's flops on this clock, so they need no synchroniser.
	always_comb begin
		prop_d  = link.proportional_only_select;
		tl_d    = link.internal_torque_limit_select;
		// Auto tuning would fight the alternate gains, so the switch is held off.
		gain_d  = link.alternate_gain_select & ~i_auto_tune_on;
		src_d   = link.command_source_select ? CMD_SRC_REG : CMD_SRC_TABLE;
		pmode_d = POS_ABSOLUTE;
		if (link.command_source_select && i_command_system_param) begin
			pmode_d = link.incremental_select ? POS_INCREMENT : POS_ABSOLUTE;
		end
		movement_complete_flag_d  = i_movement_done;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prop_q  <= RST_PROP_ONLY;
			tl_q    <= RST_TL_SEL;
			gain_q  <= RST_GAIN_SEL;
			src_q   <= CMD_SRC_TABLE;
			pmode_q <= POS_ABSOLUTE;
			movement_complete_flag_q  <= 1'h0;
		end else begin
			prop_q  <= prop_d;
			tl_q    <= tl_d;
			gain_q  <= gain_d;
			src_q   <= src_d;
			pmode_q <= pmode_d;
			movement_complete_flag_q  <= movement_complete_flag_d;
		end
	end

	// The hold counter restarts whenever clear drops, so a short pulse leaves no trace.
	// Clear acts once per assertion; it must drop before it can act again.
	always_comb begin
		hold_d  = hold_q;
		fired_d = fired_q;
		if (!link.alarm_clear_input) begin
			hold_d  = '0;
			fired_d = 1'h0;
		end else if (!fired_q) begin
			if (hold_q >= HOLD_W'(HOLD_CYCLES - 1)) begin
				fired_d = 1'h1;
			end else begin
				hold_d = hold_q + HOLD_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hold_q  <= '0;
			fired_q <= 1'h0;
		end else begin
			hold_q  <= hold_d;
			fired_q <= fired_d;
		end
	end

	// A new alarm in the clearing cycle wins over the clear.
	always_comb begin
		alarm_d  = alarm_q;
		sticky_d = sticky_q;
		if (fired_d && !fired_q && !sticky_q) begin
			alarm_d = 1'h0;
		end
		if (i_alarm_raise) begin
			alarm_d  = 1'h1;
			sticky_d = i_alarm_sticky | (sticky_q & alarm_q);
		end else if (!alarm_d) begin
			sticky_d = 1'h0;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			alarm_q  <= 1'h0;
			sticky_q <= 1'h0;
		end else begin
			alarm_q  <= alarm_d;
			sticky_q <= sticky_d;
		end
	end

	// Reset holds the stop state until the synchronised pin is seen high.
	// Brake, base and stop flag follow the next state, so all change on one edge.
	always_comb begin
		stop_d = stop_q;
		case (stop_q)
			SRIMS_RUN:  if (!emg_s2_q) stop_d = SRIMS_STOP;
			SRIMS_STOP: if (emg_s2_q) stop_d = SRIMS_RUN;
			default:    stop_d = SRIMS_STOP;
		endcase
		stop_flag_d = (stop_d == SRIMS_STOP);
		brake_d     = stop_flag_d;
		base_d      = !stop_flag_d && !alarm_d;
		// With the option set, a clear without alarm cuts the base only while held.
		if (link.alarm_clear_input && !alarm_q && i_function_select_d1_param) begin
			base_d = 1'h0;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stop_q      <= SRIMS_STOP;
			stop_flag_q <= 1'h1;
			base_q      <= 1'h0;
			brake_q     <= 1'h1;
		end else begin
			stop_q      <= stop_d;
			stop_flag_q <= stop_flag_d;
			base_q      <= base_d;
			brake_q     <= brake_d;
		end
	end

	assign link.movement_complete_flag = movement_complete_flag_q;
	assign o_proportional_only         = prop_q;
	assign o_internal_torque_limit     = tl_q;
	assign o_alternate_gain            = gain_q;
	assign o_command_source            = src_q;
	assign o_position_mode             = pmode_q;
	assign o_alarm_active              = alarm_q;
	assign o_base_enable               = base_q;
	assign o_dynamic_brake             = brake_q;
	assign o_forced_stop_state         = stop_flag_q;
endmodule : srims_device

// File: tb/srims_link_chk.sv
// Checker for the remote input link and the decoded mode outputs.
module srims_link_chk #(
	parameter int unsigned HOLD_CYCLES = 20
) (
	input wire logic       i_clk,
	input wire logic       i_nrst,
	input wire logic       proportional_only_select,
	input wire logic       internal_torque_limit_select,
	input wire logic       alternate_gain_select,
	input wire logic       command_source_select,
	input wire logic       incremental_select,
	input wire logic       alarm_clear_input,
	input wire logic       i_auto_tune_on,
	input wire logic       i_command_system_param,
	input wire logic       o_proportional_only,
	input wire logic       o_internal_torque_limit,
	input wire logic       o_alternate_gain,
	input wire logic [1:0] o_command_source,
	input wire logic [1:0] o_position_mode,
	input wire logic       o_alarm_active,
	input wire logic       o_base_enable,
	input wire logic       o_dynamic_brake,
	input wire logic       o_forced_stop_state
);
	timeunit 1ns;
	timeprecision 1ns;
	import srims_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	chk_prop_only: assert property (proportional_only_select[*5] |-> o_proportional_only)
		else $error("proportional mode missing");
	chk_torque_sel: assert property (internal_torque_limit_select[*5] |-> o_internal_torque_limit)
		else $error("internal torque limit missing");
	chk_gain_alt: assert property ((alternate_gain_select && !i_auto_tune_on)[*5] |-> o_alternate_gain)
		else $error("alternate gain missing");
	chk_table_src: assert property ((!command_source_select)[*5] |-> o_command_source == CMD_SRC_TABLE)
		else $error("table source missing");
	chk_reg_src: assert property (command_source_select[*5] |-> o_command_source == CMD_SRC_REG)
		else $error("register source missing");
	chk_incr_gate: assert property ((!command_source_select || !i_command_system_param)[*5]
		|-> o_position_mode == POS_ABSOLUTE)
		else $error("position select not gated");
	chk_incr_mode: assert property ((command_source_select && i_command_system_param && incremental_select)[*5]
		|-> o_position_mode == POS_INCREMENT)
		else $error("incremental mode missing");
	chk_stop_brake: assert property (o_forced_stop_state |-> !o_base_enable && o_dynamic_brake)
		else $error("stop state with base on");
	// A falling alarm needs the clear level seen a full hold time earlier.
	chk_clear_hold: assert property ($fell(o_alarm_active) |-> $past(alarm_clear_input, HOLD_CYCLES))
		else $error("alarm cleared too early");
	cover property ($fell(o_alarm_active));
	cover property (o_position_mode == POS_INCREMENT);
	cover property ($fell(o_forced_stop_state));
endmodule : srims_link_chk

// File: tb/test_servo_remote_input_mode_select.sv
// Self-checking bench joining the master and device ends over the link.
module test_servo_remote_input_mode_select;
	timeunit 1ns;
	timeprecision 1ns;
	import srims_pkg::*;
	localparam int unsigned HOLD = 20;
	logic       clk = 1'h0;
	logic       nrst = 1'h0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'h0;
	logic       rd = 1'h0;
	logic       stop_in = 1'h1;
	logic       raise = 1'h0;
	logic       sticky = 1'h0;
	logic       abs_sys = 1'h0;
	logic       fsel = 1'h0;
	logic       tune = 1'h0;
	logic       done = 1'h0;
	logic [7:0] rdata;
	logic       prop, tl, gain, alarm, base, brake, stop_st;
	logic [1:0] src, pos;
	int         err_total = 0;
	int         samples_checked = 0;
	srims_link_if link ();
	always #50 clk = ~clk;
	srims_master u_srims_master (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .link(link));
	srims_device #(.HOLD_CYCLES(HOLD)) u_srims_device (.i_clk(clk), .i_nrst(nrst), .link(link),
		.i_forced_stop_input(stop_in), .i_alarm_raise(raise), .i_alarm_sticky(sticky),
		.i_command_system_param(abs_sys), .i_function_select_d1_param(fsel), .i_auto_tune_on(tune),
		.i_movement_done(done), .o_proportional_only(prop), .o_internal_torque_limit(tl),
		.o_alternate_gain(gain), .o_command_source(src), .o_position_mode(pos),
		.o_alarm_active(alarm), .o_base_enable(base), .o_dynamic_brake(brake),
		.o_forced_stop_state(stop_st));
	srims_link_chk #(.HOLD_CYCLES(HOLD)) u_srims_link_chk (.i_clk(clk), .i_nrst(nrst),
		.proportional_only_select(link.proportional_only_select),
		.internal_torque_limit_select(link.internal_torque_limit_select),
		.alternate_gain_select(link.alternate_gain_select),
		.command_source_select(link.command_source_select),
		.incremental_select(link.incremental_select), .alarm_clear_input(link.alarm_clear_input),
		.i_auto_tune_on(tune), .i_command_system_param(abs_sys), .o_proportional_only(prop),
		.o_internal_torque_limit(tl), .o_alternate_gain(gain), .o_command_source(src),
		.o_position_mode(pos), .o_alarm_active(alarm), .o_base_enable(base),
		.o_dynamic_brake(brake), .o_forced_stop_state(stop_st));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	task automatic ck(input string n, input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : ck
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_reg
	task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 ck("read data", rdata, e);
	endtask : rd_reg
	task automatic mode(input logic [7:0] d, input logic [7:0] e);
		wr_reg(2'h0, d);
		tick(6);
		ck("modes", {1'h0, gain, tl, prop, src, pos}, e);
	endtask : mode
	task automatic clear_for(input int n);
		wr_reg(2'h0, 8'h20);
		tick(n);
		wr_reg(2'h0, 8'h00);
		tick(6);
	endtask : clear_for
	task automatic pulse_alarm(input logic s);
		@(posedge clk);
		raise <= 1'h1;
		sticky <= s;
		@(posedge clk);
		raise <= 1'h0;
		tick(6);
	endtask : pulse_alarm
	// The stop state exits three cycles after the pin rises, so the wait is bounded at 12 cycles.
	task automatic wait_run();
		for (int i = 0; i < 12 && stop_st !== 1'h0; i++) tick(1);
		ck("stop state", {7'h0, stop_st}, 8'h00);
		if (stop_st !== 1'h0) complete_run();
	endtask : wait_run
	task automatic s_modes();
		mode(8'h03, 8'h30);
		mode(8'h04, 8'h40);
		mode(8'h44, 8'h00);
		mode(8'h08, 8'h04);
		mode(8'h00, 8'h00);
		@(posedge clk);
		abs_sys <= 1'h1;
		mode(8'h18, 8'h05);
		mode(8'h08, 8'h04);
		mode(8'h10, 8'h00);
		@(posedge clk);
		abs_sys <= 1'h0;
		mode(8'h18, 8'h04);
		@(posedge clk);
		done <= 1'h1;
		tick(4);
		rd_reg(2'h1, 8'h01);
		wr_reg(2'h3, 8'hFF);
		rd_reg(2'h3, 8'h00);
		rd_reg(2'h0, 8'h18);
		mode(8'h1B, 8'h34);
	endtask : s_modes
	task automatic s_clear();
		wr_reg(2'h0, 8'h20);
		tick(8);
		ck("base", {7'h0, base}, 8'h01);
		@(posedge clk);
		fsel <= 1'h1;
		tick(6);
		ck("base", {7'h0, base}, 8'h00);
		@(posedge clk);
		fsel <= 1'h0;
		wr_reg(2'h0, 8'h00);
		pulse_alarm(1'h0);
		clear_for(8);
		ck("alarm", {7'h0, alarm}, 8'h01);
		clear_for(40);
		ck("alarm", {7'h0, alarm}, 8'h00);
		pulse_alarm(1'h1);
		clear_for(40);
		ck("alarm", {7'h0, alarm}, 8'h01);
	endtask : s_clear
	task automatic s_stop();
		wr_reg(2'h0, 8'h3F);
		tick(6);
		ck("stop state", {7'h0, stop_st}, 8'h00);
		@(posedge clk);
		stop_in <= 1'h0;
		tick(6);
		ck("stop outputs", {5'h0, stop_st, base, brake}, 8'h05);
		@(posedge clk);
		stop_in <= 1'h1;
		wait_run();
	endtask : s_stop
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'h1;
		wait_run();
		s_modes();
		s_clear();
		s_stop();
		complete_run();
	end
endmodule : test_servo_remote_input_mode_select
